// ==== inc/csr_pkg.sv ====
// Package of offsets, field positions and widths for the channel status block.
package csr_pkg;
  // Number of channels served, A is index 0 and B is index 1.
  localparam int unsigned NUM_CH      = 2;
  // Default width of a dynamic segment slot counter.
  localparam int unsigned SLOT_W_DEF  = 11;
  // Register byte offsets on the bus.
  localparam logic [7:0]  OFF_SW      = 8'h00;
  localparam logic [7:0]  OFF_IDLE    = 8'h04;
  localparam logic [7:0]  OFF_AGG     = 8'h08;
  localparam logic [7:0]  OFF_DYN_A   = 8'h0c;
  localparam logic [7:0]  OFF_DYN_B   = 8'h10;
  // Distance between channel A and channel B fields in a shared word.
  localparam int unsigned CH_SHIFT    = 8;
  // Symbol window snapshot fields.
  localparam int unsigned SW_VTS      = 0;
  localparam int unsigned SW_SYN      = 1;
  localparam int unsigned SW_BV       = 2;
  localparam int unsigned SW_TXC      = 3;
  localparam int unsigned SW_W        = 4;
  // Network idle time snapshot fields.
  localparam int unsigned IDLE_SYN    = 0;
  localparam int unsigned IDLE_BV     = 1;
  localparam int unsigned IDLE_W      = 2;
  // Aggregated indicator fields.
  localparam int unsigned AGG_VF      = 0;
  localparam int unsigned AGG_SYN     = 1;
  localparam int unsigned AGG_CE      = 2;
  localparam int unsigned AGG_ACS     = 3;
  localparam int unsigned AGG_SBV     = 4;
  localparam int unsigned AGG_TXC     = 5;
  localparam int unsigned AGG_W       = 6;
  // Dynamic segment word: slot in the low bits, resync flag here.
  localparam int unsigned DYN_RSY     = 16;
  // Bus encodings used by the slave.
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;
  localparam logic [31:0] WORD_ZERO   = 32'h0;
endpackage

// ==== testbench/csr_host.sv ====
// Host model: an AHB-Lite master that reads and clears the channel status words.
`timescale 1ns/1ps
module csr_host
  import csr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // The bus starts idle so that nothing is taken while reset is released.
  initial
  begin
    hsel   = 1'b0;
    haddr  = WORD_ZERO;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = HSIZE_WORD;
    hwdata = WORD_ZERO;
  end

  // One single word transfer; it must be entered just after a rising edge.
  // A write of ones clears indicators, so a zero bit leaves them alone.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the channel status block driven through the host model.
`timescale 1ns/1ps
module tb_top
  import csr_pkg::*;
;
  // One ordinary case: event kind, flags {ce,vf,txc,bv,syn,vts}, expected fields.
  typedef struct packed {
    logic [1:0] k;
    logic [5:0] f;
    logic [3:0] sw;
    logic [1:0] idle;
    logic [5:0] agg;
  } csr_row_t;

  logic              mclk, arst_n, cfg_clear;
  logic [1:0]        slot_end, sw_end, idle_end, dyn_end, vts, syn, bv, txc, vf, ce, tx_done, skip, blk;
  logic [10:0]       slot_a, slot_b;
  wire logic         hsel, hwrite, hreadyout, hresp;
  wire logic [31:0]  haddr, hwdata, hrdata;
  wire logic [1:0]   htrans;
  wire logic [2:0]   hsize;
  int                error_cnt = 0;
  int                check_count = 0;
  logic [31:0]       q;
  // Kind 0 is a slot end, 1 a symbol window end, 2 an idle time end.
  csr_row_t          rows [10] = '{
    '{2'd0, 6'h10, 4'h0, 2'h0, 6'h01}, '{2'd0, 6'h12, 4'h0, 2'h0, 6'h0b},
    '{2'd0, 6'h30, 4'h0, 2'h0, 6'h0d}, '{2'd0, 6'h14, 4'h0, 2'h0, 6'h19},
    '{2'd0, 6'h08, 4'h0, 2'h0, 6'h20}, '{2'd0, 6'h20, 4'h0, 2'h0, 6'h04},
    '{2'd1, 6'h0f, 4'hf, 2'h0, 6'h32}, '{2'd1, 6'h01, 4'h1, 2'h0, 6'h00},
    '{2'd2, 6'h1f, 4'h0, 2'h3, 6'h12}, '{2'd2, 6'h04, 4'h0, 2'h2, 6'h10}};

  csr_top #(.SLOT_W(11)) u_csr_top (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cfg_clear(cfg_clear),
    .slot_end(slot_end), .sw_end(sw_end), .idle_end(idle_end), .dyn_end(dyn_end),
    .slot_valid_test_symbol(vts), .slot_syntax_error(syn), .slot_boundary_violation(bv),
    .slot_transmit_conflict(txc), .slot_valid_frame(vf), .slot_content_error(ce),
    .dyn_tx_done(tx_done), .dyn_tx_slot_a(slot_a), .dyn_tx_slot_b(slot_b),
    .slot_skipped(skip), .blocked_transmit_slot_flag(blk));

  csr_host u_csr_host (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // A 100 ns period clock.
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compares one value seen with the value expected.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads one register over the bus and compares it.
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    u_csr_host.xfer(1'b0, a, WORD_ZERO, r);
    chk(r, e);
  endtask

  // Drops every status input; the flags are only meaningful beside a pulse.
  task automatic quiet();
    {slot_end, sw_end, idle_end, dyn_end, vts, syn, bv, txc, vf, ce, tx_done, skip, blk} <= '0;
  endtask

  // One end pulse with its flags on one channel, held for one cycle.
  task automatic ev(input logic [1:0] k, input int ch, input logic [5:0] f);
    logic [1:0] m;
    m = 2'b01 << ch;
    vts <= f[0] ? m : 2'b00;
    syn <= f[1] ? m : 2'b00;
    bv  <= f[2] ? m : 2'b00;
    txc <= f[3] ? m : 2'b00;
    vf  <= f[4] ? m : 2'b00;
    ce  <= f[5] ? m : 2'b00;
    if (k == 2'd0)
      slot_end <= m;
    else if (k == 2'd1)
      sw_end <= m;
    else
      idle_end <= m;
    @(posedge mclk);
    quiet();
  endtask

  // A configuration state transition, one cycle long.
  task automatic cfg();
    cfg_clear <= 1'b1;
    @(posedge mclk);
    cfg_clear <= 1'b0;
  endtask

  // Expects every register, and the unmapped word after them, to read zero.
  task automatic all_zero();
    for (int a = 0; a < 6; a++)
      chk_reg(8'(a * 4), WORD_ZERO);
  endtask

  // The watchdog allows about twenty times the expected run of about 250 cycles.
  initial
  begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    close_out();
  end

  initial
  begin
    {slot_end, sw_end, idle_end, dyn_end, vts, syn, bv, txc, vf, ce, tx_done, skip, blk} = '0;
    {cfg_clear, slot_a, slot_b} = '0;
    arst_n = 1'b0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    all_zero();
    $display("reset values done");
    // Every row on both channels; the other channel's fields must stay zero.
    for (int ch = 0; ch < 2; ch++)
      for (int i = 0; i < 10; i++)
      begin
        cfg();
        ev(rows[i].k, ch, rows[i].f);
        chk_reg(OFF_SW, 32'(rows[i].sw) << (CH_SHIFT * ch));
        chk_reg(OFF_IDLE, 32'(rows[i].idle) << (CH_SHIFT * ch));
        chk_reg(OFF_AGG, 32'(rows[i].agg) << (CH_SHIFT * ch));
      end
    $display("table rows done");
    // Sticky indicators: zero writes keep them, one bits clear, a set beats a clear.
    cfg();
    ev(2'd0, 0, 6'h12);
    u_csr_host.xfer(1'b1, OFF_AGG, WORD_ZERO, q);
    chk_reg(OFF_AGG, 32'h0b);
    u_csr_host.xfer(1'b1, OFF_AGG, 32'h1, q);
    chk_reg(OFF_AGG, 32'h0a);
    fork
      u_csr_host.xfer(1'b1, OFF_AGG, 32'h3, q);
      begin
        @(posedge mclk);
        syn <= 2'b01;
        vf <= 2'b01;
        slot_end <= 2'b01;
        @(posedge mclk);
        quiet();
      end
    join
    chk_reg(OFF_AGG, 32'h0b);
    u_csr_host.xfer(1'b1, OFF_AGG, 32'hffffffff, q);
    chk_reg(OFF_AGG, WORD_ZERO);
    // A snapshot word ignores writes.
    ev(2'd1, 1, 6'h01);
    u_csr_host.xfer(1'b1, OFF_SW, 32'hffffffff, q);
    chk_reg(OFF_SW, 32'h100);
    $display("host clear done");
    // Dynamic segment: the latest sent slot wins, a skip marks a resync attempt.
    tx_done <= 2'b01;
    slot_a  <= 11'h7ff;
    @(posedge mclk);
    slot_a  <= 11'h005;
    skip    <= 2'b10;
    @(posedge mclk);
    quiet();
    @(posedge mclk);
    dyn_end <= 2'b11;
    @(posedge mclk);
    dyn_end <= 2'b00;
    chk_reg(OFF_DYN_A, 32'h5);
    chk_reg(OFF_DYN_B, 32'h10000);
    blk <= 2'b01;
    @(posedge mclk);
    blk <= 2'b00;
    dyn_end <= 2'b11;
    tx_done <= 2'b10;
    slot_b  <= 11'h123;
    @(posedge mclk);
    dyn_end <= 2'b00;
    tx_done <= 2'b00;
    chk_reg(OFF_DYN_A, 32'h10000);
    chk_reg(OFF_DYN_B, 32'h123);
    $display("dynamic segment done");
    // A configuration transition clears everything, even against a snapshot event.
    ev(2'd0, 1, 6'h10);
    cfg_clear <= 1'b1;
    sw_end <= 2'b11;
    vts <= 2'b11;
    @(posedge mclk);
    cfg_clear <= 1'b0;
    quiet();
    all_zero();
    // A second reset in mid-run clears status as well.
    ev(2'd0, 0, 6'h3f);
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    all_zero();
    $display("clearing done");
    close_out();
  end
endmodule

// ==== verilog/csr_chan.sv ====
// One channel of status capture: snapshots, sticky indicators, dynamic status.
`timescale 1ns/1ps
module csr_chan
  import csr_pkg::*;
#(
  parameter int unsigned SLOT_W = SLOT_W_DEF
)(
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              cfg_clr,
  input  wire logic              slot_end,
  input  wire logic              sw_end,
  input  wire logic              idle_end,
  input  wire logic              dyn_end,
  input  wire logic              vts,
  input  wire logic              syn,
  input  wire logic              bv,
  input  wire logic              txc,
  input  wire logic              vf,
  input  wire logic              ce,
  input  wire logic              dyn_tx,
  input  wire logic [SLOT_W-1:0] dyn_slot,
  input  wire logic              skip,
  input  wire logic              blocked,
  input  wire logic [AGG_W-1:0]  agg_clr,
  output logic      [SW_W-1:0]   sw_q,
  output logic      [IDLE_W-1:0] idle_q,
  output logic      [AGG_W-1:0]  agg_q,
  output logic      [SLOT_W-1:0] last_q,
  output logic                   rsy_q
);
  // Set terms for each sticky indicator from the slot flags.
  logic [AGG_W-1:0]  agg_set;
  logic [AGG_W-1:0]  agg_nxt;
  logic [SLOT_W-1:0] run_slot_r;  // Last slot sent so far in this segment.
  logic              run_rsy_r;   // Resync seen so far in this segment.
  logic [SLOT_W-1:0] run_slot_nxt;
  logic              run_rsy_nxt;

  // Every slot counts, transmit or receive alike.
  assign agg_set[AGG_VF]  = slot_end & vf;
  assign agg_set[AGG_SYN] = (slot_end | sw_end | idle_end) & syn;
  assign agg_set[AGG_CE]  = slot_end & ce;
  assign agg_set[AGG_ACS] = slot_end & vf & (syn | ce | bv);
  assign agg_set[AGG_SBV] = (slot_end | sw_end | idle_end) & bv;
  assign agg_set[AGG_TXC] = (slot_end | sw_end) & txc;
  // A set in the clearing cycle wins, so no event is lost.
  assign agg_nxt = (agg_q & ~agg_clr) | agg_set;
  // A send or resync in the closing cycle still counts for that segment.
  assign run_slot_nxt = dyn_tx ? dyn_slot : run_slot_r;
  assign run_rsy_nxt  = run_rsy_r | skip | blocked;

  // Snapshots and sticky state; configuration transitions wipe all.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sw_q       <= '0;
      idle_q     <= '0;
      agg_q      <= '0;
      last_q     <= '0;
      rsy_q      <= 1'b0;
      run_slot_r <= '0;
      run_rsy_r  <= 1'b0;
    end
    else if (cfg_clr)
    begin
      sw_q       <= '0;
      idle_q     <= '0;
      agg_q      <= '0;
      last_q     <= '0;
      rsy_q      <= 1'b0;
      run_slot_r <= '0;
      run_rsy_r  <= 1'b0;
    end
    else
    begin
      // The flags are taken as given; test symbol and errors never mask.
      if (sw_end)
        sw_q <= {txc, bv, syn, vts};
      if (idle_end)
        idle_q <= {bv, syn};
      agg_q <= agg_nxt;
      if (dyn_end)
      begin
        // Zero reads back when nothing was sent in the segment.
        last_q     <= run_slot_nxt;
        rsy_q      <= run_rsy_nxt;
        run_slot_r <= '0;
        run_rsy_r  <= 1'b0;
      end
      else
      begin
        run_slot_r <= run_slot_nxt;
        run_rsy_r  <= run_rsy_nxt;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_sw_snap;
    sw_end && !cfg_clr |=> sw_q == $past({txc, bv, syn, vts});
  endproperty
  a_sw_snap: assert property (p_sw_snap) else $error("symbol window snapshot wrong");
  property p_idle_snap;
    idle_end && !cfg_clr |=> idle_q == $past({bv, syn});
  endproperty
  a_idle_snap: assert property (p_idle_snap) else $error("idle time snapshot wrong");
  property p_hold;
    !cfg_clr |=> ($past(agg_q) & ~$past(agg_clr) & ~agg_q) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("indicator dropped without clear");
  property p_dyn_zero;
    dyn_end && !dyn_tx && run_slot_r == '0 && !cfg_clr |=> last_q == '0;
  endproperty
  a_dyn_zero: assert property (p_dyn_zero) else $error("idle segment not zero");
  property p_rsy;
    dyn_end && (blocked || skip || run_rsy_r) && !cfg_clr |=> rsy_q;
  endproperty
  a_rsy: assert property (p_rsy) else $error("resync flag missed");
  property p_cfg;
    cfg_clr |=> agg_q == '0 && sw_q == '0 && !rsy_q;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config clear incomplete");
endmodule

// ==== verilog/csr_top.sv ====
// Channel status reporting block with its bus slave and register file.
//
// Behaviour
// - Snapshot symbol window flags per channel
// - Wakeup pattern may raise valid test symbol
// - Multiple test symbols are no syntax error
// - Wakeup indication may trail window snapshot
// - Test symbol detectable despite errors
// - Snapshot idle time errors per channel
// - Aggregate over all slots, host period
// - Valid frame indicator per channel
// - Syntax error indicator incl. window, idle
// - Content error indicator per channel
// - Valid frame plus error sets additional
// - Boundary violation incl. window, idle
// - Transmit conflict incl. window, not idle
// - Indicators stay set until host clears
// - Last dynamic slot sent, zero if none
// - Resync flag from skip or blocked slot
// - Configuration transitions clear all status
`timescale 1ns/1ps
module csr_top
  import csr_pkg::*;
#(
  parameter int unsigned SLOT_W = SLOT_W_DEF
)(
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 cfg_clear,
  input  wire logic [NUM_CH-1:0]    slot_end,
  input  wire logic [NUM_CH-1:0]    sw_end,
  input  wire logic [NUM_CH-1:0]    idle_end,
  input  wire logic [NUM_CH-1:0]    dyn_end,
  input  wire logic [NUM_CH-1:0]    slot_valid_test_symbol,
  input  wire logic [NUM_CH-1:0]    slot_syntax_error,
  input  wire logic [NUM_CH-1:0]    slot_boundary_violation,
  input  wire logic [NUM_CH-1:0]    slot_transmit_conflict,
  input  wire logic [NUM_CH-1:0]    slot_valid_frame,
  input  wire logic [NUM_CH-1:0]    slot_content_error,
  input  wire logic [NUM_CH-1:0]    dyn_tx_done,
  input  wire logic [SLOT_W-1:0]    dyn_tx_slot_a,
  input  wire logic [SLOT_W-1:0]    dyn_tx_slot_b,
  input  wire logic [NUM_CH-1:0]    slot_skipped,
  input  wire logic [NUM_CH-1:0]    blocked_transmit_slot_flag
);

  // The resync flag sits above the slot field, so the slot must fit below it.
  if (SLOT_W < 1 || SLOT_W > DYN_RSY)
  begin : g_bad_slot_w
    $error("SLOT_W must lie between 1 and the resync bit position");
  end

  // Matches the low byte of an address against a register offset.
  // The upper bits are ignored, so the map repeats through the slot window.
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[7:0] == off);
  endfunction

  // Per channel status as held in the channel slices.
  logic [SW_W-1:0]   sw_q   [NUM_CH];  // Symbol window snapshots.
  logic [IDLE_W-1:0] idle_q [NUM_CH];  // Idle time snapshots.
  logic [AGG_W-1:0]  agg_q  [NUM_CH];  // Sticky indicators.
  logic [SLOT_W-1:0] last_q [NUM_CH];  // Last dynamic slot sent.
  logic              rsy_q  [NUM_CH];  // Resync attempted flags.
  logic [SLOT_W-1:0] dslot  [NUM_CH];  // Incoming slot numbers.
  logic [AGG_W-1:0]  clr    [NUM_CH];  // Write one to clear masks.

  // Bus address phase and data phase state.
  logic              ap_take;   // A transfer is accepted this edge.
  logic              dp_wr_r;   // A write data phase is under way.
  logic [7:0]        dp_off_r;  // Offset held for the data phase.
  logic              dp_wr_nxt;
  logic [7:0]        dp_off_nxt;
  logic              dp_wr_agg; // The data phase writes the indicators.
  logic [31:0]       rd_word;   // Word read at the current address.
  logic [31:0]       hrdata_nxt;

  // Packed words as software sees them.
  logic [31:0]       sw_word;
  logic [31:0]       idle_word;
  logic [31:0]       agg_word;
  logic [31:0]       dyn_word [NUM_CH];

  // Only whole-word nonsequential transfers are taken; other sizes
  // are answered but ignored, since the map is word-only.
  assign ap_take = hsel & hready & (htrans == HTRANS_NSEQ)
                 & (hsize == HSIZE_WORD);

  // The write is applied in its data phase, when hwdata stands.
  assign dp_wr_nxt  = ap_take & hwrite;
  assign dp_off_nxt = haddr[7:0];
  assign dp_wr_agg  = dp_wr_r & (dp_off_r == OFF_AGG);

  // Channel B takes its slot number from its own port.
  assign dslot[0] = dyn_tx_slot_a;
  assign dslot[1] = dyn_tx_slot_b;

  // One slice per channel; the two channels never interact.
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    // Each channel's field group sits at its own shift in the word.
    assign clr[c] = dp_wr_agg ? hwdata[c*CH_SHIFT +: AGG_W] : '0;

    // Packs the slot and the flag into one word for this channel.
    assign dyn_word[c] = WORD_ZERO | 32'(last_q[c])
                       | (32'(rsy_q[c]) << DYN_RSY);

    // The test symbol flag is passed as detected upstream, so a
    // wakeup pattern's low phases may set it; nothing here filters it.
    // Repeated test symbols in one window raise no syntax error here.
    // Wakeup reception is reported elsewhere and may come later.
    csr_chan #(
      .SLOT_W (SLOT_W)
    ) u_chan (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .cfg_clr  (cfg_clear),
      .slot_end (slot_end[c]),
      .sw_end   (sw_end[c]),
      .idle_end (idle_end[c]),
      .dyn_end  (dyn_end[c]),
      .vts      (slot_valid_test_symbol[c]),
      .syn      (slot_syntax_error[c]),
      .bv       (slot_boundary_violation[c]),
      .txc      (slot_transmit_conflict[c]),
      .vf       (slot_valid_frame[c]),
      .ce       (slot_content_error[c]),
      .dyn_tx   (dyn_tx_done[c]),
      .dyn_slot (dslot[c]),
      .skip     (slot_skipped[c]),
      .blocked  (blocked_transmit_slot_flag[c]),
      .agg_clr  (clr[c]),
      .sw_q     (sw_q[c]),
      .idle_q   (idle_q[c]),
      .agg_q    (agg_q[c]),
      .last_q   (last_q[c]),
      .rsy_q    (rsy_q[c])
    );
  end

  // Channel A in the low byte and channel B one shift above.
  assign sw_word  = 32'(sw_q[0])  | (32'(sw_q[1])  << CH_SHIFT);
  assign idle_word = 32'(idle_q[0]) | (32'(idle_q[1]) << CH_SHIFT);
  assign agg_word = 32'(agg_q[0]) | (32'(agg_q[1]) << CH_SHIFT);

  // Read selection; unmapped offsets read as zero.
  assign rd_word = hit(haddr, OFF_SW)    ? sw_word     :
                   hit(haddr, OFF_IDLE)  ? idle_word   :
                   hit(haddr, OFF_AGG)   ? agg_word    :
                   hit(haddr, OFF_DYN_A) ? dyn_word[0] :
                   hit(haddr, OFF_DYN_B) ? dyn_word[1] :
                   WORD_ZERO;

  // Read data is sampled at the address edge so that it leaves
  // straight from a flop with no wait state. The cost is that a read
  // placed right after a clearing write still sees the old indicators.
  assign hrdata_nxt = (ap_take & ~hwrite) ? rd_word : WORD_ZERO;

  // Bus slave state. The slave never stalls and always answers OKAY.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dp_wr_r   <= 1'b0;
      dp_off_r  <= 8'h00;
      hrdata    <= WORD_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      // A new address phase is only taken while hready is high, so the
      // data phase state is replaced on every edge.
      dp_wr_r   <= dp_wr_nxt;
      dp_off_r  <= dp_off_nxt;
      hrdata    <= hrdata_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Checks on the bus side and on the clear path.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // The slave must never insert wait states.
  property p_ready;
    1'b1 |=> hreadyout && !hresp;
  endproperty
  a_ready: assert property (p_ready) else $error("slave stalled or errored");

  // A read of the idle time word returns the state seen at its address edge.
  property p_rd_idle;
    ap_take && !hwrite && hit(haddr, OFF_IDLE) |=> hrdata == $past(idle_word);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle time read wrong");

  // A symbol window read returns the snapshot, A low and B above.
  property p_rd_sw;
    ap_take && !hwrite && hit(haddr, OFF_SW)
    |=> hrdata[SW_W-1:0] == $past(sw_q[0])
        && hrdata[CH_SHIFT +: SW_W] == $past(sw_q[1]);
  endproperty
  a_rd_sw: assert property (p_rd_sw) else $error("window read wrong");

  // Writing one with no event pending clears the valid frame indicator.
  property p_w1c;
    dp_wr_agg && hwdata[AGG_VF] && !slot_end[0] && !cfg_clear
    |=> !agg_q[0][AGG_VF];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  // A valid frame in the clearing cycle keeps the indicator set.
  property p_set_wins;
    dp_wr_agg && hwdata[AGG_VF] && slot_end[0] && slot_valid_frame[0]
    && !cfg_clear |=> agg_q[0][AGG_VF];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

  // A valid frame with a content error sets the additional indicator.
  property p_acs;
    slot_end[1] && slot_valid_frame[1] && slot_content_error[1]
    && !cfg_clear |=> agg_q[1][AGG_ACS] && agg_q[1][AGG_CE];
  endproperty
  a_acs: assert property (p_acs) else $error("additional indicator missed");

  // An idle time conflict alone never raises the conflict indicator.
  property p_txc_idle;
    idle_end[0] && !slot_end[0] && !sw_end[0] && !agg_q[0][AGG_TXC]
    |=> !agg_q[0][AGG_TXC];
  endproperty
  a_txc_idle: assert property (p_txc_idle) else $error("idle conflict counted");

  // An indicator read returns both channels as they stood at its address edge.
  property p_rd_agg;
    ap_take && !hwrite && hit(haddr, OFF_AGG)
    |=> hrdata == $past(agg_word);
  endproperty
  a_rd_agg: assert property (p_rd_agg) else $error("indicator read wrong");

  // A channel A dynamic read returns its last slot and its resync flag.
  property p_rd_dyn_a;
    ap_take && !hwrite && hit(haddr, OFF_DYN_A)
    |=> hrdata[SLOT_W-1:0] == $past(last_q[0]) && hrdata[DYN_RSY] == $past(rsy_q[0]);
  endproperty
  a_rd_dyn_a: assert property (p_rd_dyn_a) else $error("dynamic A read wrong");

  // A channel B dynamic read returns its resync flag above the slot.
  property p_rd_dyn_b;
    ap_take && !hwrite && hit(haddr, OFF_DYN_B)
    |=> hrdata[DYN_RSY] == $past(rsy_q[1]) && hrdata[SLOT_W-1:0] == $past(last_q[1]);
  endproperty
  a_rd_dyn_b: assert property (p_rd_dyn_b) else $error("dynamic B read wrong");

  // Outside a read data phase the read bus rests at zero.
  property p_rd_quiet;
    !(ap_take && !hwrite) |=> hrdata == WORD_ZERO;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not at rest");

  // A valid frame at a slot end raises channel B's valid frame indicator.
  property p_vf_set;
    slot_end[1] && slot_valid_frame[1] && !cfg_clear
    |=> agg_q[1][AGG_VF];
  endproperty
  a_vf_set: assert property (p_vf_set) else $error("valid frame missed");

  // An idle time end is no slot, so a valid frame flag there is not counted.
  property p_vf_idle;
    idle_end[0] && !slot_end[0] && !agg_q[0][AGG_VF]
    |=> !agg_q[0][AGG_VF];
  endproperty
  a_vf_idle: assert property (p_vf_idle) else $error("idle valid frame counted");

  // A syntax error in the symbol window counts as well.
  property p_syn_sw;
    sw_end[0] && slot_syntax_error[0] && !cfg_clear
    |=> agg_q[0][AGG_SYN];
  endproperty
  a_syn_sw: assert property (p_syn_sw) else $error("window syntax error missed");

  // So does a syntax error in the idle time.
  property p_syn_idle;
    idle_end[1] && slot_syntax_error[1] && !cfg_clear
    |=> agg_q[1][AGG_SYN];
  endproperty
  a_syn_idle: assert property (p_syn_idle) else $error("idle syntax error missed");

  // A content error at a slot end raises the content error indicator.
  property p_ce_set;
    slot_end[0] && slot_content_error[0] && !cfg_clear
    |=> agg_q[0][AGG_CE];
  endproperty
  a_ce_set: assert property (p_ce_set) else $error("content error missed");

  // A clean valid frame leaves the additional indicator alone.
  property p_acs_none;
    slot_end[0] && slot_valid_frame[0] && !agg_q[0][AGG_ACS]
    && !(slot_syntax_error[0] || slot_content_error[0] || slot_boundary_violation[0])
    |=> !agg_q[0][AGG_ACS];
  endproperty
  a_acs_none: assert property (p_acs_none) else $error("additional indicator false");

  // A boundary violation in the idle time raises the boundary indicator.
  property p_sbv_idle;
    idle_end[1] && slot_boundary_violation[1] && !cfg_clear
    |=> agg_q[1][AGG_SBV];
  endproperty
  a_sbv_idle: assert property (p_sbv_idle) else $error("idle boundary violation missed");

  // A conflict in the symbol window raises the conflict indicator.
  property p_txc_sw;
    sw_end[1] && slot_transmit_conflict[1] && !cfg_clear
    |=> agg_q[1][AGG_TXC];
  endproperty
  a_txc_sw: assert property (p_txc_sw) else $error("window conflict missed");

  // A frame sent in the closing cycle is the one reported.
  property p_dyn_last;
    dyn_end[1] && dyn_tx_done[1] && !cfg_clear
    |=> last_q[1] == $past(dyn_tx_slot_b);
  endproperty
  a_dyn_last: assert property (p_dyn_last) else $error("last dynamic slot wrong");

  // A configuration transition also empties the dynamic and idle time status.
  property p_cfg_all;
    cfg_clear |=> last_q[0] == '0 && idle_q[1] == '0 && agg_q[1] == '0;
  endproperty
  a_cfg_all: assert property (p_cfg_all) else $error("config clear left status");

  // Main scenarios worth seeing in simulation.
  c_clear: cover property (dp_wr_agg && hwdata[AGG_SYN]);
  c_dyn:   cover property (dyn_end[1] && dyn_tx_done[1]);
  c_cfg:   cover property (cfg_clear ##1 sw_end[0]);
  c_rd:    cover property (ap_take && !hwrite && hit(haddr, OFF_DYN_A));
endmodule
